// *** logic/eps_defs.svh ***
// Constants for the exception pending status block
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH
`define EPS_AW        12
`define EPS_NIRQ      43
`define EPS_NEXC      59
`define EPS_NEV       3
`define EPS_OFS_ICS   12'hD04
`define EPS_OFS_BPM   12'hD20
`define EPS_OFS_FMK   12'hD24
`define EPS_OFS_STS   12'hD28
`define EPS_OFS_MSK   12'hD2C
`define EPS_SEL_NONE  3'h0
`define EPS_SEL_ICS   3'h1
`define EPS_SEL_BPM   3'h2
`define EPS_SEL_FMK   3'h3
`define EPS_SEL_STS   3'h4
`define EPS_SEL_MSK   3'h5
`define EPS_B_NONMASKABLE_SET_PENDING  31
`define EPS_B_SVSET   28
`define EPS_B_SVCLR   27
`define EPS_B_TKSET   26
`define EPS_B_TKCLR   25
`define EPS_B_RSV24   24
`define EPS_B_DBG     23
`define EPS_B_ISRPND  22
`define EPS_F_RSV     21:18
`define EPS_F_VECPND  17:12
`define EPS_B_RETURN_TO_BASE 11
`define EPS_F_ACTIVE_EXCEPTION_NUMBER  5:0
`define EPS_EX_NONE   6'h00
`define EPS_EX_NMI    6'h02
`define EPS_EX_HARD   6'h03
`define EPS_EX_MEM    6'h04
`define EPS_EX_BUS    6'h05
`define EPS_EX_USAGE  6'h06
`define EPS_EX_SVC    6'h0B
`define EPS_EX_PSV    6'h0E
`define EPS_EX_TICK   6'h0F
`define EPS_EX_IRQ0   6'h10
`define EPS_RESP_OK   2'h0
`define EPS_RESP_ERR  2'h2
`endif

// *** logic/eps_pkg.sv ***
// Types shared by the exception pending status block
`default_nettype none
package eps_pkg;
  typedef struct packed {
    logic [42:0] irq_pending;
    logic [42:0] irq_enable;
    logic [3:0]  fault_pending;
    logic [2:0]  fault_enable;
    logic        supervisor_call_pending;
    logic        debug_halted;
    logic        preempted_active;
    logic [5:0]  active_exception;
    logic        entry_strobe;
    logic [5:0]  entered_exception;
  } eps_core_s;
  typedef struct packed {
    logic       nonmaskable;
    logic       service_call;
    logic       tick;
    logic [5:0] highest_pending_exception;
  } eps_pend_s;
endpackage
`default_nettype wire

// *** logic/eps_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module eps_pin_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Pin and clean level
  input  wire logic pin,
  output logic      level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      level_r <= 1'b0;
    else if (s2_r == s3_r)
      level_r <= s3_r;
  end

  assign level = level_r;
endmodule
`default_nettype wire

// *** logic/eps_prio_pick.sv ***
// Lowest-numbered request wins
`timescale 1ns/1ps
`include "eps_defs.svh"
`default_nettype none
module eps_prio_pick (
  // Requests by exception number
  input  wire logic [`EPS_NEXC-1:0] req,
  // Winning exception number
  output logic      [5:0]           num
);
  always_comb
  begin
    num = `EPS_EX_NONE;
    for (int i = `EPS_NEXC - 1; i > 0; i--)
    begin
      if (req[i])
        num = 6'(i);
    end
  end
endmodule
`default_nettype wire

// *** logic/eps_ics_top.sv ***
// Interrupt control and state register with pending status logic
// How it works
// - The tick clear-pending bit is write-only and reads back as zero here.
// - Bit 24 and bits 21:18 always read zero; software keeps them on read-modify-write.
// - Bit 23 reads 1 when release from halt would take an interrupt.
// - Bit 23 reads 0 whenever the core is not halted in debug.
// - Bit 22 reads 1 while any interrupt is pending, 0 after reset.
// - Bit 22 ignores the non-maskable interrupt and the faults.
// - Bits 17:12 hold the highest-priority pending enabled exception, 0 after reset.
// - That choice honours the base priority and fault masks, not the global mask.
// - Bits 17:12 read zero when nothing is pending.
// - Non-maskable is 2, hard fault 3, memory 4, bus 5, usage fault 6.
// - Supervisor call is 11, service call 14, tick 15, external vector n is 16+n.
// - Codes 1, 7 to 10, 12 and 13 never appear in bits 17:12.
// - Writing 1 to the tick clear-pending bit removes tick pending unless a tick event or tick set-pending write comes in the same cycle; 0 does nothing.
// - Bit 11 reads 0 while preempted active exceptions remain, else 1.
// - Bits 5:0 show the active exception number, 0 in thread execution.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "eps_defs.svh"
`default_nettype none
module eps_ics_top (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // AXI4-Lite write
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [`EPS_AW-1:0]    awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic      [1:0]            bresp,
  // AXI4-Lite read
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [`EPS_AW-1:0]    araddr,
  input  wire logic [2:0]            arprot,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp,
  // Core side
  input  wire eps_pkg::eps_core_s    core_in,
  input  wire logic                  nmi_pin,
  input  wire logic                  tick_event,
  output eps_pkg::eps_pend_s         pend_out,
  // Interrupt
  output logic                       irq
);
  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  logic [1:0]           rresp_r;
  logic                 aw_have_r;
  logic [`EPS_AW-1:0]   aw_addr_r;
  logic                 w_have_r;
  logic [31:0]          w_data_r;
  logic [3:0]           w_strb_r;
  logic                 nmi_pend_r;
  logic                 psv_pend_r;
  logic                 tick_pend_r;
  logic [5:0]           bpm_r;
  logic                 fmk_r;
  logic [`EPS_NEV-1:0]  sts_r;
  logic [`EPS_NEV-1:0]  msk_r;
  logic                 irq_r;
  logic [5:0]           highest_pending_exception_r;
  logic                 any_irq_pending_r;
  logic                 dbg_r;
  logic                 nmi_lvl_r;
  logic                 rd_ics_r;
  logic                 nmi_lvl;
  logic                 wr_fire;
  logic [2:0]           wr_sel;
  logic [31:0]          wbits;
  logic                 ics_wr;
  logic [`EPS_NIRQ-1:0] irq_req;
  logic [`EPS_NEXC-1:0] req;
  logic [5:0]           pick;
  logic [`EPS_NEV-1:0]  ev;
  logic [31:0]          ics_val;

  // Register decode
  function automatic logic [2:0] reg_sel(input logic [`EPS_AW-1:0] a);
    case (a)
      `EPS_OFS_ICS: reg_sel = `EPS_SEL_ICS;
      `EPS_OFS_BPM: reg_sel = `EPS_SEL_BPM;
      `EPS_OFS_FMK: reg_sel = `EPS_SEL_FMK;
      `EPS_OFS_STS: reg_sel = `EPS_SEL_STS;
      `EPS_OFS_MSK: reg_sel = `EPS_SEL_MSK;
      default:      reg_sel = `EPS_SEL_NONE;
    endcase
  endfunction

  // Masked by fault mask or base priority
  function automatic logic blocked(input logic [5:0] n, input logic [5:0] base, input logic fault);
    blocked = fault | ((base != `EPS_EX_NONE) && (n >= base));
  endfunction

  eps_pin_sync u_nmi_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (nmi_pin),
    .level (nmi_lvl)
  );

  // Write channel capture
  assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
  assign wr_sel  = reg_sel(aw_addr_r);
  assign wbits   = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign ics_wr  = wr_fire & (wr_sel == `EPS_SEL_ICS);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b1;
      aw_addr_r <= '0;
    end
    else if (awvalid && awready_r)
    begin
      aw_have_r <= 1'b1;
      awready_r <= 1'b0;
      aw_addr_r <= awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      w_have_r <= 1'b0;
      wready_r <= 1'b1;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else if (wvalid && wready_r)
    begin
      w_have_r <= 1'b1;
      wready_r <= 1'b0;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
    else if (wr_fire)
    begin
      w_have_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `EPS_RESP_OK;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_sel == `EPS_SEL_NONE) ? `EPS_RESP_ERR : `EPS_RESP_OK;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  // Pending state, hardware set wins over clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      nmi_lvl_r <= 1'b0;
    else
      nmi_lvl_r <= nmi_lvl;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      nmi_pend_r <= 1'b0;
    else if ((nmi_lvl & ~nmi_lvl_r) || (ics_wr && wbits[`EPS_B_NONMASKABLE_SET_PENDING]))
      nmi_pend_r <= 1'b1;
    else if (core_in.entry_strobe && core_in.entered_exception == `EPS_EX_NMI)
      nmi_pend_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      psv_pend_r <= 1'b0;
    else if (ics_wr && wbits[`EPS_B_SVSET])
      psv_pend_r <= 1'b1;
    else if ((ics_wr && wbits[`EPS_B_SVCLR])
             || (core_in.entry_strobe && core_in.entered_exception == `EPS_EX_PSV))
      psv_pend_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      tick_pend_r <= 1'b0;
    else if (tick_event || (ics_wr && wbits[`EPS_B_TKSET]))
      tick_pend_r <= 1'b1;
    else if ((ics_wr && wbits[`EPS_B_TKCLR])
             || (core_in.entry_strobe && core_in.entered_exception == `EPS_EX_TICK))
      tick_pend_r <= 1'b0;
  end

  // Mask registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bpm_r <= `EPS_EX_NONE;
      fmk_r <= 1'b0;
      msk_r <= '0;
    end
    else if (wr_fire)
    begin
      if (wr_sel == `EPS_SEL_BPM && w_strb_r[0])
        bpm_r <= w_data_r[5:0];
      if (wr_sel == `EPS_SEL_FMK && w_strb_r[0])
        fmk_r <= w_data_r[0];
      if (wr_sel == `EPS_SEL_MSK && w_strb_r[0])
        msk_r <= w_data_r[`EPS_NEV-1:0];
    end
  end

  // Sticky events, write one to clear, set wins
  assign ev = {tick_event & ~tick_pend_r,
               ics_wr & wbits[`EPS_B_SVSET] & ~psv_pend_r,
               nmi_lvl & ~nmi_lvl_r};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sts_r <= '0;
    else if (wr_fire && wr_sel == `EPS_SEL_STS)
      sts_r <= (sts_r & ~wbits[`EPS_NEV-1:0]) | ev;
    else
      sts_r <= sts_r | ev;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(sts_r & msk_r);
  end

  // Eligible requests by exception number
  genvar g;
  generate
    for (g = 0; g < `EPS_NIRQ; g++)
    begin : g_irq
      assign irq_req[g] = core_in.irq_pending[g] & core_in.irq_enable[g]
                          & ~blocked(6'(g) + `EPS_EX_IRQ0, bpm_r, fmk_r);
    end
  endgenerate

  assign req = {irq_req,
                tick_pend_r & ~blocked(`EPS_EX_TICK, bpm_r, fmk_r),
                psv_pend_r & ~blocked(`EPS_EX_PSV, bpm_r, fmk_r),
                2'b00,
                core_in.supervisor_call_pending & ~blocked(`EPS_EX_SVC, bpm_r, fmk_r),
                4'h0,
                core_in.fault_pending[3:1] & core_in.fault_enable
                  & {~blocked(`EPS_EX_USAGE, bpm_r, fmk_r),
                     ~blocked(`EPS_EX_BUS, bpm_r, fmk_r),
                     ~blocked(`EPS_EX_MEM, bpm_r, fmk_r)},
                core_in.fault_pending[0] & ~fmk_r,
                nmi_pend_r,
                2'b00};

  eps_prio_pick u_pick (
    .req (req),
    .num (pick)
  );

  // Status fields, one clock behind their inputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      highest_pending_exception_r <= `EPS_EX_NONE;
      any_irq_pending_r <= 1'b0;
      dbg_r     <= 1'b0;
    end
    else
    begin
      highest_pending_exception_r <= pick;
      any_irq_pending_r <= (|core_in.irq_pending) | core_in.supervisor_call_pending
                   | psv_pend_r | tick_pend_r;
      dbg_r     <= core_in.debug_halted & (pick != `EPS_EX_NONE);
    end
  end

  // Read image of the control and state register
  always_comb
  begin
    ics_val                  = '0;
    ics_val[`EPS_B_NONMASKABLE_SET_PENDING]   = nmi_pend_r;
    ics_val[`EPS_B_SVSET]    = psv_pend_r;
    ics_val[`EPS_B_TKSET]    = tick_pend_r;
    ics_val[`EPS_B_DBG]      = dbg_r;
    ics_val[`EPS_B_ISRPND]   = any_irq_pending_r;
    ics_val[`EPS_F_VECPND]   = highest_pending_exception_r;
    ics_val[`EPS_B_RETURN_TO_BASE]  = ~core_in.preempted_active;
    ics_val[`EPS_F_ACTIVE_EXCEPTION_NUMBER]   = core_in.active_exception;
  end

  // Read channel
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `EPS_RESP_OK;
      rd_ics_r  <= 1'b0;
    end
    else if (arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= `EPS_RESP_OK;
      rd_ics_r  <= reg_sel(araddr) == `EPS_SEL_ICS;
      case (reg_sel(araddr))
        `EPS_SEL_ICS: rdata_r <= ics_val;
        `EPS_SEL_BPM: rdata_r <= {26'h0, bpm_r};
        `EPS_SEL_FMK: rdata_r <= {31'h0, fmk_r};
        `EPS_SEL_STS: rdata_r <= {29'h0, sts_r};
        `EPS_SEL_MSK: rdata_r <= {29'h0, msk_r};
        default:
        begin
          rdata_r <= '0;
          rresp_r <= `EPS_RESP_ERR;
        end
      endcase
    end
    else if (rvalid_r && rready)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready  = awready_r;
  assign wready   = wready_r;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign arready  = arready_r;
  assign rvalid   = rvalid_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;
  assign irq      = irq_r;
  assign pend_out = {nmi_pend_r, psv_pend_r, tick_pend_r, highest_pending_exception_r};

  // Checks
  chk_clear_bits_zero: assert property (@(posedge clock) disable iff (!rst_n)
    rvalid_r && rd_ics_r |-> !rdata_r[`EPS_B_TKCLR] && !rdata_r[`EPS_B_SVCLR])
    else $error("clear-pending bits read nonzero");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    rvalid_r && rd_ics_r |-> !rdata_r[`EPS_B_RSV24] && rdata_r[`EPS_F_RSV] == 4'h0)
    else $error("reserved bits read nonzero");
  chk_debug_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    core_in.debug_halted && pick != `EPS_EX_NONE |=> dbg_r)
    else $error("debug release flag missing");
  chk_debug_flag_off: assert property (@(posedge clock) disable iff (!rst_n)
    !core_in.debug_halted |=> !dbg_r)
    else $error("debug release flag set outside debug");
  chk_pending_excludes: assert property (@(posedge clock) disable iff (!rst_n)
    !(|core_in.irq_pending) && !core_in.supervisor_call_pending && !psv_pend_r && !tick_pend_r |=> !any_irq_pending_r)
    else $error("pending flag set by excluded source");
  chk_fault_mask: assert property (@(posedge clock) disable iff (!rst_n)
    fmk_r && $stable(fmk_r) |=> highest_pending_exception_r == `EPS_EX_NONE || highest_pending_exception_r == `EPS_EX_NMI)
    else $error("fault mask ignored");
  chk_vector_idle: assert property (@(posedge clock) disable iff (!rst_n)
    req == '0 |=> highest_pending_exception_r == `EPS_EX_NONE)
    else $error("vector nonzero with nothing pending");
  chk_nmi_code: assert property (@(posedge clock) disable iff (!rst_n)
    nmi_pend_r |=> highest_pending_exception_r == `EPS_EX_NMI)
    else $error("nonmaskable code wrong");
  chk_tick_code: assert property (@(posedge clock) disable iff (!rst_n)
    req[14:0] == '0 && req[15] |=> highest_pending_exception_r == `EPS_EX_TICK)
    else $error("tick code wrong");
  chk_reserved_codes: assert property (@(posedge clock) disable iff (!rst_n)
    !(highest_pending_exception_r inside {6'h01, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0D}))
    else $error("reserved vector code reported");
  chk_tick_clear: assert property (@(posedge clock) disable iff (!rst_n)
    ics_wr && wbits[`EPS_B_TKCLR] && !wbits[`EPS_B_TKSET] && !tick_event |=> !tick_pend_r)
    else $error("tick clear-pending ignored");
  chk_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
    |(sts_r & msk_r) |=> irq)
    else $error("interrupt output missing");
  cov_tick_read: cover property (@(posedge clock) disable iff (!rst_n)
    rvalid_r && rd_ics_r && rdata_r[`EPS_B_TKSET]);
  cov_nmi_win: cover property (@(posedge clock) disable iff (!rst_n)
    highest_pending_exception_r == `EPS_EX_NMI);
  cov_debug_flag: cover property (@(posedge clock) disable iff (!rst_n) dbg_r);
  cov_slave_error: cover property (@(posedge clock) disable iff (!rst_n)
    bvalid_r && bresp_r == `EPS_RESP_ERR);
endmodule
`default_nettype wire

// *** dv/eps_core_model.sv ***
// Behavioural core that feeds the block and takes exceptions
`timescale 1ns/1ps
`default_nettype none
module eps_core_model (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Bench controls
  input  wire eps_pkg::eps_core_s want,
  input  wire logic               take,
  input  wire logic               slow,
  input  wire logic               nmi_go,
  input  wire logic               tick_go,
  // Block side
  input  wire eps_pkg::eps_pend_s pend,
  output eps_pkg::eps_core_s      core_in,
  output logic                    nmi_pin,
  output logic                    tick_event
);
  logic [2:0] wait_r;
  logic [2:0] pin_r;
  // Levels follow the bench, entry pulse fires when the wait runs out
  always_ff @(posedge clock)
  begin
    core_in <= want;
    core_in.entry_strobe <= rst_n && wait_r == 3'h1;
    core_in.entered_exception <= (rst_n && wait_r == 3'h1) ? pend.highest_pending_exception : 6'h00;
  end
  // Prompt or slow acceptance of the highest pending exception
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wait_r <= 3'h0;
    else if (wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
    else if (take && pend.highest_pending_exception != 6'h00)
      wait_r <= slow ? 3'h5 : 3'h1;
  end
  // Pin pulse of seven cycles, low when idle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pin_r <= 3'h0;
    else if (nmi_go)
      pin_r <= 3'h7;
    else if (pin_r != 3'h0)
      pin_r <= pin_r - 3'h1;
  end
  assign nmi_pin = pin_r != 3'h0;
  always_ff @(posedge clock)
  begin
    tick_event <= rst_n && tick_go;
  end
endmodule
`default_nettype wire

// *** dv/exception_pending_status_test.sv ***
// Self-checking bench for the exception pending status block
`timescale 1ns/1ps
`include "eps_defs.svh"
`default_nettype none
module exception_pending_status_test;
  logic               clock, rst_n, irq, take, slow, nmi_go, tick_go, nmi_pin, tick_event;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, nmi_p, psv_p, tick_p, fmk;
  logic [11:0]        awaddr, araddr;
  logic [31:0]        wdata, rdata, seed, d;
  logic [1:0]         bresp, rresp, r;
  logic [5:0]         bpm;
  logic [2:0]         sts, msk;
  eps_pkg::eps_core_s core_in, want, w;
  eps_pkg::eps_pend_s pend_out;
  int                 err_count, checks_done;

  eps_ics_top u_dut (.clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .core_in(core_in), .nmi_pin(nmi_pin),
    .tick_event(tick_event), .pend_out(pend_out), .irq(irq));
  eps_core_model u_core (.clock(clock), .rst_n(rst_n), .want(want), .take(take), .slow(slow),
    .nmi_go(nmi_go), .tick_go(tick_go), .pend(pend_out), .core_in(core_in),
    .nmi_pin(nmi_pin), .tick_event(tick_event));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic elig(input int n);
    return n == 2 || (!fmk && (n == 3 || bpm == 6'h00 || n < int'(bpm)));
  endfunction
  function automatic logic [5:0] exp_vec();
    logic [58:0] p;
    p = '0;
    p[2] = nmi_p;
    p[3] = want.fault_pending[0];
    for (int k = 0; k < 3; k++) p[4+k] = want.fault_pending[k+1] & want.fault_enable[k];
    p[11] = want.supervisor_call_pending;
    p[14] = psv_p;
    p[15] = tick_p;
    p[58:16] = want.irq_pending & want.irq_enable;
    for (int n = 2; n < 59; n++) if (p[n] && elig(n)) return 6'(n);
    return 6'h00;
  endfunction
  function automatic logic [31:0] exp_ics();
    logic [31:0] v;
    v = '0;
    v[31] = nmi_p;
    v[28] = psv_p;
    v[26] = tick_p;
    v[23] = want.debug_halted && exp_vec() != 6'h00;
    v[22] = |want.irq_pending | want.supervisor_call_pending | psv_p | tick_p;
    v[17:12] = exp_vec();
    v[11] = !want.preempted_active;
    v[5:0] = want.active_exception;
    return v;
  endfunction

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_resp("write response", er, bresp);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic check_all();
    repeat (3) @(posedge clock);
    cmp_word("pend_out", {23'h0, nmi_p, psv_p, tick_p, exp_vec()}, 32'(pend_out));
    cmp_word("irq", {31'h0, |(sts & msk)}, {31'h0, irq});
    rd(`EPS_OFS_ICS);
    cmp_word("control state", exp_ics(), d);
    cmp_word("legal code", 32'h1, {31'h0, !(d[17:12] inside {6'h01, [6'h07:6'h0A], 6'h0C, 6'h0D})});
    cmp_resp("read response", `EPS_RESP_OK, r);
    rd(`EPS_OFS_STS);
    cmp_word("status", {29'h0, sts}, d);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    repeat (6000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, take, slow, nmi_go, tick_go} = '0;
    {awaddr, araddr, wdata, want} = '0;
    {nmi_p, psv_p, tick_p, fmk, bpm, sts, msk} = '0;
    seed = 32'h19FF;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    check_all();
    rd(12'h100);
    cmp_word("unmapped data", 32'h0, d);
    cmp_resp("unmapped response", `EPS_RESP_ERR, r);
    wr(12'h100, 32'hFFFF_FFFF, `EPS_RESP_ERR);
    // Directed corners, then random core states and masks
    for (int i = 0; i < 42; i++)
    begin
      w = '0;
      d = (i < 2) ? 32'h0 : rnd();
      w.irq_pending = 43'({rnd(), rnd()} & {rnd(), rnd()});
      w.irq_enable = 43'({rnd(), rnd()});
      w.fault_pending = 4'(rnd() & rnd());
      w.fault_enable = 3'(rnd());
      if (i == 0) {w.irq_pending, w.irq_enable, w.fault_pending} = {43'h400_0000_0000, 43'h400_0000_0000, 4'h0};
      if (i == 1) {w.irq_pending, w.fault_pending, w.fault_enable} = {43'h0, 4'hF, 3'h7};
      w.supervisor_call_pending = d[0] & d[1];
      w.debug_halted = d[2];
      w.preempted_active = d[3];
      w.active_exception = d[9:4];
      wr(`EPS_OFS_BPM, {26'h0, d[10] ? d[16:11] : 6'h00}, `EPS_RESP_OK);
      wr(`EPS_OFS_FMK, {31'h0, &d[19:17]}, `EPS_RESP_OK);
      bpm = d[10] ? d[16:11] : 6'h00;
      fmk = &d[19:17];
      want <= w;
      check_all();
    end
    rd(`EPS_OFS_BPM);
    cmp_word("base mask", {26'h0, bpm}, d);
    want <= '0;
    wr(`EPS_OFS_BPM, 32'h0, `EPS_RESP_OK);
    wr(`EPS_OFS_FMK, 32'h0, `EPS_RESP_OK);
    {bpm, fmk, msk, psv_p, tick_p, sts} = {6'h00, 1'b0, 3'h7, 1'b1, 1'b1, 3'h2};
    wr(`EPS_OFS_MSK, 32'h7, `EPS_RESP_OK);
    wr(`EPS_OFS_ICS, 32'h1000_0000, `EPS_RESP_OK);
    wr(`EPS_OFS_ICS, 32'h0400_0000, `EPS_RESP_OK);
    check_all();
    wr(`EPS_OFS_ICS, 32'h0, `EPS_RESP_OK);
    check_all();
    wr(`EPS_OFS_ICS, 32'h0200_0000, `EPS_RESP_OK);
    tick_p = 1'b0;
    check_all();
    wr(`EPS_OFS_ICS, 32'h0800_0000, `EPS_RESP_OK);
    wr(`EPS_OFS_STS, 32'h2, `EPS_RESP_OK);
    {psv_p, sts} = {1'b0, 3'h0};
    check_all();
    tick_go <= 1'b1;
    @(posedge clock);
    tick_go <= 1'b0;
    {tick_p, sts} = {1'b1, 3'h4};
    check_all();
    wr(`EPS_OFS_MSK, 32'h0, `EPS_RESP_OK);
    msk = 3'h0;
    check_all();
    wr(`EPS_OFS_MSK, 32'h7, `EPS_RESP_OK);
    wr(`EPS_OFS_STS, 32'h4, `EPS_RESP_OK);
    {msk, sts} = {3'h7, 3'h0};
    nmi_go <= 1'b1;
    @(posedge clock);
    nmi_go <= 1'b0;
    repeat (8) @(posedge clock);
    {nmi_p, sts} = {1'b1, 3'h1};
    wr(`EPS_OFS_ICS, 32'h1000_0000, `EPS_RESP_OK);
    {psv_p, sts} = {1'b1, 3'h3};
    check_all();
    // Core takes the three pending exceptions, prompt and slow
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      slow <= k[0];
      take <= 1'b1;
      @(posedge clock);
      take <= 1'b0;
      repeat (8) @(posedge clock);
      if (k == 0) nmi_p = 1'b0;
      else if (k == 1) psv_p = 1'b0;
      else tick_p = 1'b0;
      check_all();
    end
    wr(`EPS_OFS_ICS, 32'h8000_0000, `EPS_RESP_OK);
    nmi_p = 1'b1;
    check_all();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    {nmi_p, msk, sts} = '0;
    check_all();
    wrap_up();
  end
endmodule
`default_nettype wire
